// ===== src/ext_irq_pkg.sv
// Shared constants for the external interrupt and response timing block.
package ext_irq_pkg;

   // Machine cycle: six states of two phases, one phase per clock.
   localparam int unsigned PHASES      = 12;
   localparam int unsigned PH_W        = 4;
   localparam logic [3:0]  PH_S2P2     = 4'h3;
   localparam logic [3:0]  PH_S5P2     = 4'h9;
   localparam logic [3:0]  PH_LAST     = 4'hB;
   localparam logic [3:0]  PH_RESET    = 4'h0;

   // Timing figures in machine cycles, except OSC_PER_SAMPLE in oscillator periods.
   localparam int unsigned OSC_PER_SAMPLE = 12;
   localparam logic [1:0]  CALL_CYCLES    = 2'h2;
   localparam logic [3:0]  LAT_MIN        = 4'h3;
   localparam logic [3:0]  LAT_MAX        = 4'h9;

   // Sources in polling order, highest first.
   localparam int unsigned NSRC     = 6;
   localparam logic [2:0]  SRC_EXT0 = 3'h0;
   localparam logic [2:0]  SRC_TMR0 = 3'h1;
   localparam logic [2:0]  SRC_EXT1 = 3'h2;
   localparam logic [2:0]  SRC_TMR1 = 3'h3;
   localparam logic [2:0]  SRC_SER  = 3'h4;
   localparam logic [2:0]  SRC_TMR2 = 3'h5;

   // Vector addresses.
   localparam logic [15:0] VEC_EXT0 = 16'h0003;
   localparam logic [15:0] VEC_TMR0 = 16'h000B;
   localparam logic [15:0] VEC_EXT1 = 16'h0013;
   localparam logic [15:0] VEC_TMR1 = 16'h001B;
   localparam logic [15:0] VEC_SER  = 16'h0023;
   localparam logic [15:0] VEC_TMR2 = 16'h002B;
   localparam logic [15:0] VEC_NONE = 16'h0000;

   // Request flag positions in the flag register.
   localparam int unsigned FL_EXT0 = 0;
   localparam int unsigned FL_TF0  = 1;
   localparam int unsigned FL_EXT1 = 2;
   localparam int unsigned FL_TF1  = 3;
   localparam int unsigned FL_RX   = 4;
   localparam int unsigned FL_TX   = 5;
   localparam int unsigned FL_TF2  = 6;
   localparam int unsigned FL_TIMER2_EXTERNAL_FLAG = 7;

   // Register byte offsets.
   localparam logic [7:0] OFS_TRIG     = 8'h00;
   localparam logic [7:0] OFS_ENABLE   = 8'h04;
   localparam logic [7:0] OFS_PRIO     = 8'h08;
   localparam logic [7:0] OFS_FLAGS    = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_STATE    = 8'h18;

   // Field positions and reset values.
   localparam int unsigned EN_GLOBAL    = 7;
   localparam logic [1:0]  TRIG_RST     = 2'h0;
   localparam logic [7:0]  ENABLE_RST   = 8'h00;
   localparam logic [5:0]  PRIO_RST     = 6'h00;
   localparam logic [5:0]  IRQ_MASK_RST = 6'h00;

   typedef enum logic [1:0] {
      CALL_IDLE = 2'b00,
      CALL_PUSH = 2'b01,
      CALL_LOAD = 2'b11
   } call_state_t;

endpackage

// ===== src/ext_irq_response.sv
// External interrupt flags, polling and hardware vector call sequencing with APB registers.
`timescale 1ns/1ps
module ext_irq_response (
   // Clock, reset, enable
   input  wire logic        sys_clk_i,
   input  wire logic        srst_i,
   input  wire logic        ce_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Request pins
   input  wire logic        ext0_request_pin_n_i,
   input  wire logic        ext1_request_pin_n_i,
   // Flag-setting events from timers and serial port
   input  wire logic        timer0_overflow_i,
   input  wire logic        timer1_overflow_i,
   input  wire logic        timer2_overflow_i,
   input  wire logic        timer2_external_i,
   input  wire logic        serial_rx_done_i,
   input  wire logic        serial_tx_done_i,
   // CPU sequencer status, valid in the last phase of a machine cycle
   input  wire logic        instr_final_cycle_i,
   input  wire logic        return_from_irq_i,
   input  wire logic        enable_prio_access_i,
   // CPU sequencer commands
   output logic             hw_vector_call_o,
   output logic             call_active_o,
   output logic [15:0]      vector_addr_o,
   output logic [3:0]       cycle_phase_o,
   // Interrupt
   output logic             irq_o
);
   import ext_irq_pkg::*;

   logic [3:0]  ph_reg;
   logic        s5p2;
   logic        last_ph;
   logic [1:0]  trig_reg;
   logic [7:0]  enable_reg;
   logic [5:0]  prio_reg;
   logic [5:0]  irq_stat_reg;
   logic [5:0]  irq_mask_reg;
   logic [7:0]  flags;
   logic [7:0]  poll_reg;
   logic [5:0]  evt_pend_reg;
   logic [5:0]  evt_flag_reg;
   logic [5:0]  evt_in;
   logic [1:0]  ext_flag;
   logic [1:0]  pin_n;
   logic [7:0]  sw_clr;
   logic        wr_acc;
   logic [5:0]  src_req;
   logic [5:0]  cand;
   logic [5:0]  cand_hi;
   logic [5:0]  cand_lo;
   logic        cpu_block;
   logic        take;
   logic        take_hi;
   logic [2:0]  take_src;
   logic [2:0]  act_src_reg;
   logic        hi_act_reg;
   logic        lo_act_reg;
   logic [1:0]  call_left_reg;
   logic [3:0]  lat_cnt_reg;
   logic [3:0]  last_lat_reg;
   logic [5:0]  vec_clr;
   call_state_t call_state_reg;

   // Lowest index wins within a level.
   function automatic logic [2:0] first_set(input logic [5:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [15:0] vec_of(input logic [2:0] src);
      logic [15:0] a;
      case (src)
         SRC_EXT0: a = VEC_EXT0;
         SRC_TMR0: a = VEC_TMR0;
         SRC_EXT1: a = VEC_EXT1;
         SRC_TMR1: a = VEC_TMR1;
         SRC_SER:  a = VEC_SER;
         SRC_TMR2: a = VEC_TMR2;
         default:  a = VEC_NONE;
      endcase
      return a;
   endfunction

   // Machine cycle phase counter.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         ph_reg <= PH_RESET;
      end else if (ce_i) begin
         ph_reg <= (ph_reg == PH_LAST) ? PH_RESET : ph_reg + 4'h1;
      end
   end
   assign s5p2    = (ph_reg == PH_S5P2);
   assign last_ph = (ph_reg == PH_LAST);

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         cycle_phase_o <= PH_RESET;
      end else if (ce_i) begin
         cycle_phase_o <= (ph_reg == PH_LAST) ? PH_RESET : ph_reg + 4'h1;
      end
   end

   // APB access and software clears of the request flags.
   assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
   assign sw_clr = (wr_acc && paddr_i == OFS_FLAGS) ? pwdata_i[7:0] : 8'h00;

   // External request pins.
   assign pin_n = {ext1_request_pin_n_i, ext0_request_pin_n_i};
   assign vec_clr[SRC_EXT0] = take && (take_src == SRC_EXT0);
   assign vec_clr[SRC_TMR0] = take && (take_src == SRC_TMR0);
   assign vec_clr[SRC_EXT1] = take && (take_src == SRC_EXT1);
   assign vec_clr[SRC_TMR1] = take && (take_src == SRC_TMR1);
   assign vec_clr[SRC_SER]  = 1'b0;
   assign vec_clr[SRC_TMR2] = 1'b0;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ext
         ext_pin_sampler u_smp (
            .sys_clk_i  (sys_clk_i),
            .srst_i     (srst_i),
            .ce_i       (ce_i),
            .sample_i   (s5p2),
            .pin_n_i    (pin_n[g]),
            .trig_sel_i (trig_reg[g]),
            .vec_clr_i  (vec_clr[2 * g]),
            .sw_clr_i   (sw_clr[2 * g]),
            .flag_o     (ext_flag[g])
         );
      end
   endgenerate

   // Internal events: 0 tf0, 1 tf1, 2 rx, 3 tx, 4 tf2, 5 timer2_external_flag.
   assign evt_in = {timer2_external_i, timer2_overflow_i, serial_tx_done_i,
                    serial_rx_done_i, timer1_overflow_i, timer0_overflow_i};

   localparam int unsigned EV_FL [6] = '{FL_TF0, FL_TF1, FL_RX, FL_TX, FL_TF2, FL_TIMER2_EXTERNAL_FLAG};

   generate
      for (g = 0; g < 6; g++) begin : g_evt
         localparam logic [3:0] SET_PH = (g == 4) ? PH_S2P2 : PH_S5P2;
         logic set_now;
         logic hw_clr;
         assign set_now = (ph_reg == SET_PH) && (evt_pend_reg[g] || evt_in[g]);
         assign hw_clr  = (g == 0) ? vec_clr[SRC_TMR0] :
                          (g == 1) ? vec_clr[SRC_TMR1] : 1'b0;
         always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
               evt_pend_reg[g] <= 1'b0;
            end else if (ce_i) begin
               evt_pend_reg[g] <= !set_now && (evt_pend_reg[g] || evt_in[g]);
            end
         end
         // Setting wins over a clear in the same clock.
         always_ff @(posedge sys_clk_i) begin
            if (srst_i) begin
               evt_flag_reg[g] <= 1'b0;
            end else if (ce_i) begin
               if (set_now) begin
                  evt_flag_reg[g] <= 1'b1;
               end else if (hw_clr || sw_clr[EV_FL[g]]) begin
                  evt_flag_reg[g] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   assign flags = {evt_flag_reg[5], evt_flag_reg[4], evt_flag_reg[3], evt_flag_reg[2],
                   evt_flag_reg[1], ext_flag[1], evt_flag_reg[0], ext_flag[0]};

   // Poll snapshot: the values present after S5P2 of the previous cycle.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         poll_reg <= 8'h00;
      end else if (ce_i && last_ph) begin
         poll_reg <= flags;
      end
   end

   // Timer 2 overflow is polled live in the cycle it is set.
   assign src_req = {poll_reg[FL_TIMER2_EXTERNAL_FLAG] | flags[FL_TF2],
                     poll_reg[FL_RX] | poll_reg[FL_TX],
                     poll_reg[FL_TF1], poll_reg[FL_EXT1],
                     poll_reg[FL_TF0], poll_reg[FL_EXT0]};
   assign cand    = src_req & enable_reg[5:0] & {6{enable_reg[EN_GLOBAL]}};
   assign cand_hi = cand & prio_reg;
   assign cand_lo = cand & ~prio_reg;

   assign cpu_block = !instr_final_cycle_i
                    || return_from_irq_i
                    || enable_prio_access_i;
   assign take_hi   = (cand_hi != 6'h00) && !hi_act_reg;
   assign take      = ce_i && last_ph && (call_state_reg == CALL_IDLE) && !cpu_block
                    && (take_hi || ((cand_lo != 6'h00) && !hi_act_reg && !lo_act_reg));
   assign take_src  = take_hi ? first_set(cand_hi) : first_set(cand_lo);

   // Two-cycle hardware call sequence.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         call_state_reg <= CALL_IDLE;
         call_left_reg  <= 2'h0;
      end else if (ce_i) begin
         case (call_state_reg)
            CALL_IDLE: begin
               if (take) begin
                  call_state_reg <= CALL_PUSH;
                  call_left_reg  <= CALL_CYCLES;
               end
            end
            CALL_PUSH: begin
               if (last_ph) begin
                  call_state_reg <= CALL_LOAD;
                  call_left_reg  <= call_left_reg - 2'h1;
               end
            end
            CALL_LOAD: begin
               if (last_ph) begin
                  call_state_reg <= CALL_IDLE;
                  call_left_reg  <= 2'h0;
               end
            end
            default: begin
               call_state_reg <= CALL_IDLE;
               call_left_reg  <= 2'h0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         hw_vector_call_o <= 1'b0;
         call_active_o    <= 1'b0;
         vector_addr_o    <= VEC_NONE;
         act_src_reg      <= 3'h0;
      end else if (ce_i) begin
         hw_vector_call_o <= take;
         call_active_o    <= take || (call_state_reg == CALL_PUSH)
                          || (call_state_reg == CALL_LOAD && !last_ph);
         if (take) begin
            vector_addr_o <= vec_of(take_src);
            act_src_reg   <= take_src;
         end
      end
   end

   // In-progress levels; a return releases the higher one first.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         hi_act_reg <= 1'b0;
         lo_act_reg <= 1'b0;
      end else if (ce_i) begin
         if (take && take_hi) begin
            hi_act_reg <= 1'b1;
         end else if (take) begin
            lo_act_reg <= 1'b1;
         end else if (last_ph && return_from_irq_i && hi_act_reg) begin
            hi_act_reg <= 1'b0;
         end else if (last_ph && return_from_irq_i) begin
            lo_act_reg <= 1'b0;
         end
      end
   end

   // Machine cycles from the first poll that sees a candidate to the first routine cycle.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         lat_cnt_reg  <= 4'h0;
         last_lat_reg <= 4'h0;
      end else if (ce_i && last_ph) begin
         if (call_state_reg == CALL_LOAD) begin
            last_lat_reg <= lat_cnt_reg + 4'h2;
            lat_cnt_reg  <= 4'h0;
         end else if (call_state_reg == CALL_PUSH || cand != 6'h00) begin
            lat_cnt_reg  <= (lat_cnt_reg == 4'hF) ? lat_cnt_reg : lat_cnt_reg + 4'h1;
         end else begin
            lat_cnt_reg  <= 4'h0;
         end
      end
   end

   // Control registers written over APB.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         trig_reg     <= TRIG_RST;
         enable_reg   <= ENABLE_RST;
         prio_reg     <= PRIO_RST;
         irq_mask_reg <= IRQ_MASK_RST;
      end else if (ce_i && wr_acc) begin
         case (paddr_i)
            OFS_TRIG:     trig_reg     <= pwdata_i[1:0];
            OFS_ENABLE:   enable_reg   <= pwdata_i[7:0];
            OFS_PRIO:     prio_reg     <= pwdata_i[5:0];
            OFS_IRQ_MASK: irq_mask_reg <= pwdata_i[5:0];
            default: begin
            end
         endcase
      end
   end

   // Sticky per-source call events; a new call wins over a write-one clear.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_stat_reg <= 6'h00;
      end else if (ce_i) begin
         for (int i = 0; i < NSRC; i++) begin
            if (take && take_src == 3'(i)) begin
               irq_stat_reg[i] <= 1'b1;
            end else if (wr_acc && paddr_i == OFS_IRQ_STAT && pwdata_i[i]) begin
               irq_stat_reg[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // APB answer: ready in the first access cycle, error on unmapped offsets.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else if (ce_i) begin
         pready_o  <= psel_i && !penable_i;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         if (psel_i && !penable_i) begin
            case (paddr_i)
               OFS_TRIG:     prdata_o <= {30'h0, trig_reg};
               OFS_ENABLE:   prdata_o <= {24'h0, enable_reg};
               OFS_PRIO:     prdata_o <= {26'h0, prio_reg};
               OFS_FLAGS:    prdata_o <= {24'h0, flags};
               OFS_IRQ_STAT: prdata_o <= {26'h0, irq_stat_reg};
               OFS_IRQ_MASK: prdata_o <= {26'h0, irq_mask_reg};
               OFS_STATE:    prdata_o <= {16'h0, last_lat_reg, 1'b0, act_src_reg,
                                          2'h0, hi_act_reg, lo_act_reg, 2'h0, call_left_reg};
               default:      pslverr_o <= 1'b1;
            endcase
         end
      end
   end

   level_follow_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (ce_i && s5p2 && !trig_reg[0] && !sw_clr[FL_EXT0]) |=> (ext_flag[0] == !$past(pin_n[0])))
      else $error("level mode flag does not follow the sampled pin");

   edge_phase_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(ext_flag[1]) |-> ($past(ph_reg) == PH_S5P2))
      else $error("external flag set outside the sampling phase");

   trans_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (hw_vector_call_o && act_src_reg == SRC_EXT1 && trig_reg[1]) |-> !ext_flag[1])
      else $error("transition flag not cleared by the vector call");

   level_keep_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (hw_vector_call_o && act_src_reg == SRC_EXT0 && !trig_reg[0]) |-> $stable(ext_flag[0]))
      else $error("level mode flag disturbed by the vector call");

   tmr_phase_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(evt_flag_reg[0]) |-> ($past(ph_reg) == PH_S5P2))
      else $error("timer 0 flag set outside S5P2");

   tf2_phase_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(evt_flag_reg[4]) |-> ($past(ph_reg) == PH_S2P2))
      else $error("timer 2 overflow flag set outside S2P2");

   call_len_a: assert property (@(posedge sys_clk_i) disable iff (srst_i || !ce_i)
      hw_vector_call_o |-> call_active_o ##12 call_active_o ##12 !call_active_o)
      else $error("hardware call does not last two machine cycles");

   poll_gate_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      hw_vector_call_o |-> $past(instr_final_cycle_i && !return_from_irq_i
                                 && !enable_prio_access_i && ph_reg == PH_LAST))
      else $error("vector call outside a final cycle or after a return");

   prio_block_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (hw_vector_call_o && $past(hi_act_reg)) |-> 1'b0)
      else $error("vector call while a high level routine runs");

   vec_addr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      hw_vector_call_o |-> (vector_addr_o == vec_of(act_src_reg)))
      else $error("vector address does not match the source");

   latency_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $changed(last_lat_reg) |-> (last_lat_reg > LAT_MIN))
      else $error("response faster than the minimum");

   ext0_call_c: cover property (@(posedge sys_clk_i) hw_vector_call_o && act_src_reg == SRC_EXT0);
   nested_c:    cover property (@(posedge sys_clk_i) hi_act_reg && lo_act_reg);
   tf2_call_c:  cover property (@(posedge sys_clk_i) hw_vector_call_o && act_src_reg == SRC_TMR2);
   irq_out_c:   cover property (@(posedge sys_clk_i) irq_o);
endmodule

// ===== src/ext_pin_sampler.sv
// Samples one active-low request pin per machine cycle and keeps its request flag.
`timescale 1ns/1ps
module ext_pin_sampler (
   // Clock and control
   input  wire logic sys_clk_i,
   input  wire logic srst_i,
   input  wire logic ce_i,
   input  wire logic sample_i,
   // Pin and mode
   input  wire logic pin_n_i,
   input  wire logic trig_sel_i,
   // Flag clears
   input  wire logic vec_clr_i,
   input  wire logic sw_clr_i,
   // Flag
   output logic      flag_o
);
   logic prev_high_reg;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         prev_high_reg <= 1'b0;
      end else if (ce_i && sample_i) begin
         prev_high_reg <= pin_n_i;
      end
   end

   // A detection in the clearing cycle wins over the clear.
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         flag_o <= 1'b0;
      end else if (ce_i) begin
         if (sample_i && !trig_sel_i) begin
            flag_o <= !pin_n_i;
         end else if (sample_i && trig_sel_i && prev_high_reg && !pin_n_i) begin
            flag_o <= 1'b1;
         end else if ((vec_clr_i && trig_sel_i) || sw_clr_i) begin
            flag_o <= 1'b0;
         end
      end
   end
endmodule

// ===== tb/ext_interrupt_response_logic_test.sv
// Self-checking bench for the external interrupt response block.
`timescale 1ns/1ps
module ext_interrupt_response_logic_test;
   import ext_irq_pkg::*;
   logic        clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, call, act, irq;
   logic        tmr0 = 0, rx = 0, tx = 0, tf2 = 0, fin = 1, ret = 0;
   logic [1:0]  want_n = 2'h3, pin_n;
   logic [15:0] vec;
   logic [3:0]  phase;
   int          miscompares = 0, total_checks = 0, calls = 0, n, c;
   initial begin
      forever #5 clk = ~clk;
   end
   req_source src_u (.sys_clk_i(clk), .phase_i(phase), .want_n_i(want_n), .pin_n_o(pin_n));
   ext_irq_response dut_u (
      .sys_clk_i(clk), .srst_i(srst), .ce_i(ce),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr),
      .ext0_request_pin_n_i(pin_n[0]), .ext1_request_pin_n_i(pin_n[1]),
      .timer0_overflow_i(tmr0), .timer1_overflow_i(1'b0),
      .timer2_overflow_i(tf2), .timer2_external_i(1'b0),
      .serial_rx_done_i(rx), .serial_tx_done_i(tx),
      .instr_final_cycle_i(fin), .return_from_irq_i(ret),
      .enable_prio_access_i(1'b0), .hw_vector_call_o(call),
      .call_active_o(act), .vector_addr_o(vec),
      .cycle_phase_o(phase), .irq_o(irq)
   );
   always @(posedge clk) begin
      if (call === 1'b1) calls++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_call();
      n = 0;
      while (call !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (2) @(posedge clk);
   endtask
   task automatic retire();
      repeat (30) @(posedge clk);
      ret <= 1'b1;
      repeat (12) @(posedge clk);
      ret <= 1'b0;
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      apb(1'b0, OFS_TRIG, 32'h0);
      chk(rd, 32'(TRIG_RST));
      apb(1'b0, OFS_ENABLE, 32'h0);
      chk(rd, 32'(ENABLE_RST));
      apb(1'b0, OFS_PRIO, 32'h0);
      chk(rd, 32'(PRIO_RST));
      apb(1'b0, OFS_IRQ_MASK, 32'h0);
      chk(rd, 32'(IRQ_MASK_RST));
      apb(1'b0, 8'h1C, 32'h0);
      chk(32'(err), 32'h1);
      // Level request on the first pin, with the interrupt output masked at first.
      apb(1'b1, OFS_ENABLE, 32'h81);
      want_n <= 2'h2;
      while (pin_n[0] !== 1'b0) @(posedge clk);
      wait_call();
      chk(32'(n + 25 > 36 && n + 25 < 108), 32'h1);
      chk(32'(vec), 32'(VEC_EXT0));
      chk(32'(irq), 32'h0);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(32'(rd[0]), 32'h1);
      c = calls;
      retire();
      chk(32'(calls - c), 32'h0);
      wait_call();
      chk(32'(n < 120), 32'h1);
      want_n <= 2'h3;
      repeat (30) @(posedge clk);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(32'(rd[0]), 32'h0);
      retire();
      // Edge request on the second pin, held off by an unfinished instruction.
      apb(1'b1, OFS_TRIG, 32'h2);
      apb(1'b1, OFS_ENABLE, 32'h85);
      fin <= 1'b0;
      c = calls;
      want_n <= 2'h1;
      repeat (60) @(posedge clk);
      chk(32'(calls - c), 32'h0);
      fin <= 1'b1;
      wait_call();
      chk(32'(vec), 32'(VEC_EXT1));
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(32'(rd[2]), 32'h0);
      retire();
      c = calls;
      repeat (60) @(posedge clk);
      chk(32'(calls - c), 32'h0);
      want_n <= 2'h3;
      // Timer and serial events land in the flag register and clear by writing ones.
      tmr0 <= 1'b1;
      rx   <= 1'b1;
      tx   <= 1'b1;
      tf2  <= 1'b1;
      @(posedge clk);
      tmr0 <= 1'b0;
      rx   <= 1'b0;
      tx   <= 1'b0;
      tf2  <= 1'b0;
      repeat (24) @(posedge clk);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd, 32'h72);
      apb(1'b1, OFS_FLAGS, 32'h72);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd, 32'h0);
      summarize();
   end
endmodule

// ===== tb/req_source.sv
// Model of the two request sources that drive the active-low pins.
`timescale 1ns/1ps
module req_source (
   // Clock and phase
   input  wire logic       sys_clk_i,
   input  wire logic [3:0] phase_i,
   // Wanted and driven levels
   input  wire logic [1:0] want_n_i,
   output logic      [1:0] pin_n_o
);
   initial pin_n_o = 2'h3;
   // Levels move only at a cycle start, so each one holds a whole machine cycle.
   always @(posedge sys_clk_i) begin
      if (phase_i == ext_irq_pkg::PH_RESET) begin
         pin_n_o <= want_n_i;
      end
   end
endmodule
